// file: logic/headset_detect_pkg.sv
// constants shared by the headset and button detection block
// assumes a 40 MHz core clock and slow, bouncy mechanical sense inputs
//
// Behaviour
// - detection runs only while enable bit set
// - type field: 00 none, 01 plain, 11 mic
// - jack debounce 16..512 ms, tick 2..64 ms
// - button debounce off, 8, 16, 32 ms
// - press flag sets and stays set
// - reading the flag register clears it
// - present flag reads 1 while headset detected
// - coupling bit: 0 capless, 1 ac-coupled
// - writable fully-differential stereo configuration bit
// - writable pseudodifferential stereo configuration bit
package headset_detect_pkg;

    // register offsets
    localparam logic [7:0] config_a_offset = 8'h0d;
    localparam logic [7:0] config_b_offset = 8'h0e;

    // config a field positions
    localparam int detect_enable_bit = 7;
    localparam int type_msb          = 6;
    localparam int type_lsb          = 5;
    localparam int jack_deb_msb      = 4;
    localparam int jack_deb_lsb      = 2;
    localparam int button_deb_msb    = 1;
    localparam int button_deb_lsb    = 0;

    // config b field positions
    localparam int coupling_bit      = 7;
    localparam int fully_diff_bit    = 6;
    localparam int press_flag_bit    = 5;
    localparam int present_bit       = 4;
    localparam int pseudo_diff_bit   = 3;

    // values after reset, and the type codes
    localparam logic [2:0] jack_deb_reset   = 3'h0;
    localparam logic [1:0] button_deb_reset = 2'h0;
    localparam logic [1:0] type_none        = 2'h0;
    localparam logic [1:0] type_no_mic      = 2'h1;
    localparam logic [1:0] type_with_mic    = 2'h3;
    localparam logic [7:0] read_unmapped    = 8'h00;

    // timing: base sampling tick of 1 ms at 40 MHz
    localparam int clock_hz          = 40_000_000;
    localparam int base_tick_us      = 1000;
    localparam int base_tick_cycles  = (clock_hz / 1_000_000) * base_tick_us;

    // every debounce window spans eight sampling ticks
    localparam logic [2:0] debounce_last_sample = 3'h7;

endpackage : headset_detect_pkg

// file: logic/debounce_if.sv
// carrier between the detection top and one glitch filter
// assumes both ends run on the same clock
interface debounce_if;
    logic sample;   // sampling tick, one-cycle pulse
    logic raw;      // synchronised sense level
    logic bypass;   // follow raw without filtering
    logic level;    // filtered level

    modport owner  (output sample, output raw, output bypass, input level);
    modport filter (input sample, input raw, input bypass, output level);
endinterface : debounce_if

// file: logic/glitch_filter.sv
// glitch filter: level changes after eight consecutive samples differing from it
// assumes raw is already synchronised to clock
module glitch_filter (
    // clock and reset
    input wire logic    clock,
    input wire logic    rst_n,
    // filter side of the carrier
    debounce_if.filter  link
);

    logic [2:0] agree_count;  // samples differing from current level

    // count consecutive disagreeing samples, flip on the eighth
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            agree_count <= 3'h0;
            link.level  <= 1'b0;
        end else if (link.bypass) begin
            // no debounce: level tracks input every cycle
            agree_count <= 3'h0;
            link.level  <= link.raw;
        end else if (link.sample) begin
            if (link.raw == link.level) begin
                // one agreeing sample restarts the window
                agree_count <= 3'h0;
            end else if (agree_count == headset_detect_pkg::debounce_last_sample) begin
                agree_count <= 3'h0;
                link.level  <= link.raw;
            end else begin
                agree_count <= agree_count + 3'h1;
            end
        end
    end

endmodule : glitch_filter

// file: logic/headset_button_detect.sv
// headset jack and microphone button detection with two config registers
// assumes sense pins are asynchronous; register port on the core clock
module headset_button_detect #(
    parameter int tick_cycles = headset_detect_pkg::base_tick_cycles
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // sense pins, asynchronous
    input  wire logic       jack_sense,
    input  wire logic       mic_sense,
    input  wire logic       button_sense,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_write,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    // status and configuration outputs
    output logic            headset_present,
    output logic      [1:0] headset_type,
    output logic            coupling_ac,
    output logic            stereo_fully_diff,
    output logic            stereo_pseudo_diff
);

    // sampling tick at 2^shift ms, derived from the ms counter
    function automatic logic tick_at(input logic [5:0] count, input logic [2:0] shift);
        logic [5:0] mask;
        mask = ~(6'h3f << shift);
        return (count & mask) == 6'h00;
    endfunction : tick_at

    // register decode, used by both read and write paths
    function automatic logic hits(input logic [7:0] addr, input logic [7:0] offset);
        return addr == offset;
    endfunction : hits

    logic        detect_enable;   // config a enable bit
    logic [2:0]  jack_deb;        // jack debounce code
    logic [1:0]  button_deb;      // button debounce code
    logic        press_flag;      // sticky press flag
    logic [1:0]  jack_sync;       // two-stage syncs, bit 0 first stage
    logic [1:0]  mic_sync;
    logic [1:0]  button_sync;
    logic [15:0] pre_count;       // 1 ms prescaler
    logic        ms_tick;         // one-cycle pulse each ms
    logic [5:0]  ms_count;        // counts ms ticks, wraps at 64
    logic        button_prev;     // last filtered button level
    logic        press_event;     // rising edge of filtered button

    debounce_if jack_link ();
    debounce_if mic_link ();
    debounce_if button_link ();

    // two flip-flops on every pin before any logic reads it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            jack_sync   <= 2'h0;
            mic_sync    <= 2'h0;
            button_sync <= 2'h0;
        end else begin
            jack_sync   <= {jack_sync[0], jack_sense};
            mic_sync    <= {mic_sync[0], mic_sense};
            button_sync <= {button_sync[0], button_sense};
        end
    end
    // only the second stage feeds the filters; the first may be metastable

    // base 1 ms tick; long count is a parameter so sims can shorten it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pre_count <= 16'h0000;
            ms_tick   <= 1'b0;
        end else if (pre_count == 16'(tick_cycles - 1)) begin
            pre_count <= 16'h0000;
            ms_tick   <= 1'b1;
        end else begin
            pre_count <= pre_count + 16'h0001;
            ms_tick   <= 1'b0;
        end
    end

    // free ms counter; power-of-two ticks are its low bits at zero
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ms_count <= 6'h00;
        end else if (ms_tick) begin
            ms_count <= ms_count + 6'h01;
        end
    end

    // jack tick 2 to 64 ms
    // jack and mic share the jack window; code + 1 is the ms shift
    assign jack_link.sample  = ms_tick && tick_at(ms_count, jack_deb + 3'h1);
    assign jack_link.raw     = jack_sync[1];
    assign jack_link.bypass  = 1'b0;
    assign mic_link.sample   = jack_link.sample;
    assign mic_link.raw      = mic_sync[1];
    assign mic_link.bypass   = 1'b0;

    // button tick 1 to 4 ms
    // code 0 bypasses; codes 1..3 sample at 1, 2, 4 ms
    assign button_link.sample = ms_tick && tick_at(ms_count, {1'b0, button_deb} - 3'h1);
    assign button_link.raw    = button_sync[1];
    assign button_link.bypass = (button_deb == 2'h0);

    glitch_filter jack_filter (
        .clock (clock),
        .rst_n (rst_n),
        .link  (jack_link.filter)
    );

    glitch_filter mic_filter (
        .clock (clock),
        .rst_n (rst_n),
        .link  (mic_link.filter)
    );

    glitch_filter button_filter (
        .clock (clock),
        .rst_n (rst_n),
        .link  (button_link.filter)
    );

    // config a writable fields
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            detect_enable <= 1'b0;
            jack_deb      <= headset_detect_pkg::jack_deb_reset;
            button_deb    <= headset_detect_pkg::button_deb_reset;
        end else if (reg_write && hits(reg_addr, headset_detect_pkg::config_a_offset)) begin
            detect_enable <= reg_wdata[headset_detect_pkg::detect_enable_bit];
            // reserved codes 110, 111 are not filtered; software avoids them
            jack_deb      <= reg_wdata[headset_detect_pkg::jack_deb_msb:
                                       headset_detect_pkg::jack_deb_lsb];
            button_deb    <= reg_wdata[headset_detect_pkg::button_deb_msb:
                                       headset_detect_pkg::button_deb_lsb];
        end
    end

    // config b writable bits; reserved low bits are not stored
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            coupling_ac        <= 1'b0;
            stereo_fully_diff  <= 1'b0;
            stereo_pseudo_diff <= 1'b0;
        end else if (reg_write && hits(reg_addr, headset_detect_pkg::config_b_offset)) begin
            coupling_ac        <= reg_wdata[headset_detect_pkg::coupling_bit];
            stereo_fully_diff  <= reg_wdata[headset_detect_pkg::fully_diff_bit];
            stereo_pseudo_diff <= reg_wdata[headset_detect_pkg::pseudo_diff_bit];
        end
    end

    // detection results, registered
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            headset_present <= 1'b0;
            headset_type    <= headset_detect_pkg::type_none;
        end else if (!detect_enable) begin
            headset_present <= 1'b0;
            headset_type    <= headset_detect_pkg::type_none;
        end else begin
            headset_present <= jack_link.level;
            if (!jack_link.level) begin
                headset_type <= headset_detect_pkg::type_none;
            end else if (mic_link.level) begin
                headset_type <= headset_detect_pkg::type_with_mic;
            end else begin
                headset_type <= headset_detect_pkg::type_no_mic;
            end
        end
    end

    // press is a rising edge of the filtered button level
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            button_prev <= 1'b0;
        end else begin
            button_prev <= button_link.level;
        end
    end
    assign press_event = detect_enable && button_link.level && !button_prev;

    // sticky press flag; a new press outranks the read clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            press_flag <= 1'b0;
        end else if (press_event) begin
            press_flag <= 1'b1;
        end else if (reg_read && hits(reg_addr, headset_detect_pkg::config_b_offset)) begin
            press_flag <= 1'b0;
        end
    end

    // read data registered one cycle after the read strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= headset_detect_pkg::read_unmapped;
        end else if (reg_read) begin
            if (hits(reg_addr, headset_detect_pkg::config_a_offset)) begin
                reg_rdata <= {detect_enable, headset_type, jack_deb, button_deb};
            end else if (hits(reg_addr, headset_detect_pkg::config_b_offset)) begin
                // reserved low bits read as zero
                reg_rdata <= {coupling_ac, stereo_fully_diff, press_flag,
                              headset_present, stereo_pseudo_diff, 3'h0};
            end else begin
                reg_rdata <= headset_detect_pkg::read_unmapped;
            end
        end
    end

endmodule : headset_button_detect

// file: testbench/headset_button_detect_assertions.sv
// checker for the headset detection block, watching its top ports only
// assumes it is bound to the top module; one clock, synchronous reset
module headset_button_detect_checker (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst_n,
    // sense and register port
    input wire logic       button_sense,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_write,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    // status and configuration
    input wire logic       headset_present,
    input wire logic [1:0] headset_type,
    input wire logic       coupling_ac,
    input wire logic       stereo_fully_diff,
    input wire logic       stereo_pseudo_diff
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       enable;  // mirror of the detection enable bit
    logic [2:0] low_run; // cycles the button pin has been released
    // track enable from writes to config a
    always_ff @(posedge clock) begin
        if (!rst_n) enable <= 1'b0;
        else if (reg_write && reg_addr == 8'h0d) enable <= reg_wdata[7];
    end
    // saturating count; long enough to outlast sync and result lag
    always_ff @(posedge clock) begin
        if (!rst_n || button_sense) low_run <= 3'h0;
        else if (low_run != 3'h7) low_run <= low_run + 3'h1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_type_not_reserved: assert property (headset_type != 2'h2)
        else $error("reserved headset type code");
    a_present_type_pair: assert property (headset_type[0] == headset_present)
        else $error("present flag disagrees with type");
    a_disabled_clear: assert property (
        (!enable)[*3] |-> !headset_present && headset_type == 2'h0)
        else $error("results not cleared while disabled");
    a_coupling_write: assert property (
        reg_write && reg_addr == 8'h0e |=> coupling_ac == $past(reg_wdata[7]))
        else $error("coupling bit not written");
    a_fdiff_write: assert property (
        reg_write && reg_addr == 8'h0e |=> stereo_fully_diff == $past(reg_wdata[6]))
        else $error("fully differential bit not written");
    a_pdiff_write: assert property (
        reg_write && reg_addr == 8'h0e |=> stereo_pseudo_diff == $past(reg_wdata[3]))
        else $error("pseudo differential bit not written");
    a_unmapped_read: assert property (
        reg_read && reg_addr != 8'h0d && reg_addr != 8'h0e |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!reg_read |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_cfgb_readback: assert property (
        reg_read && !reg_write && reg_addr == 8'h0e
        |=> reg_rdata[7] == $past(coupling_ac)
        && reg_rdata[6] == $past(stereo_fully_diff)
        && reg_rdata[3] == $past(stereo_pseudo_diff) && reg_rdata[2:0] == 3'h0)
        else $error("config b read data wrong");
    // reads of the bench come two cycles apart; the pin is long released
    a_flag_clears: assert property (
        reg_read && reg_addr == 8'h0e && low_run == 3'h7
        ##2 reg_read && reg_addr == 8'h0e |=> !reg_rdata[5])
        else $error("press flag survived a read");
endmodule : headset_button_detect_checker

// file: testbench/headset_sense_stub.sv
// far-side model: jack, microphone and button contacts that chatter
// assumes the bench sets wanted levels on the falling edge
module headset_sense_stub (
    // clock
    input  wire logic clock,
    // wanted contact levels
    input  wire logic want_jack,
    input  wire logic want_mic,
    input  wire logic want_btn,
    // sense pins towards the device
    output logic      jack_sense,
    output logic      mic_sense,
    output logic      button_sense
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] chat = 4'h0; // chatter cycles left
    logic [2:0] last = 3'h0; // wanted levels seen last cycle
    // any change chatters for six cycles, like a real contact
    always @(negedge clock) begin
        last <= {want_jack, want_mic, want_btn};
        if ({want_jack, want_mic, want_btn} != last) chat <= 4'h6;
        else if (chat != 4'h0) chat <= chat - 4'h1;
    end
    assign {jack_sense, mic_sense, button_sense} = chat[0] ? ~last : last;
endmodule : headset_sense_stub

// file: testbench/test_headset_button_detect.sv
// self-checking bench for the headset detection block
// assumes the sense stub and checker are compiled first
module test_headset_button_detect;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int tc = 4; // short base tick keeps windows brief
    logic       clock, rst_n, reg_write, reg_read, want_jack, want_mic, want_btn;
    logic       jack_sense, mic_sense, button_sense, headset_present;
    logic       coupling_ac, stereo_fully_diff, stereo_pseudo_diff;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, v;
    logic [1:0] headset_type;
    logic [31:0] seed = 32'h705f5071; // fixed xorshift state
    int         n_fail = 0, cmp_count = 0, n, t;
    headset_button_detect #(.tick_cycles(tc)) dut (.clock, .rst_n, .jack_sense, .mic_sense,
        .button_sense, .reg_addr, .reg_write, .reg_wdata, .reg_read, .reg_rdata,
        .headset_present, .headset_type, .coupling_ac, .stereo_fully_diff, .stereo_pseudo_diff);
    headset_sense_stub stub (.clock, .want_jack, .want_mic, .want_btn, .jack_sense,
        .mic_sense, .button_sense);
    // repeatable random values
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // one-cycle write strobe, driven on the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = x;
        reg_write = 1'b1;
        @(negedge clock);
        reg_write = 1'b0;
    endtask : wr
    // one-cycle read strobe; data settles one edge later
    task automatic rd(input logic [7:0] a, output logic [7:0] x);
        @(negedge clock);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clock);
        reg_read = 1'b0;
        x = reg_rdata;
    endtask : rd
    // bounded wait for the present flag to reach a level
    task automatic wait_lvl(input logic e, input int lim, output int k);
        k = 0;
        while (headset_present !== e && k < lim) begin
            @(negedge clock);
            k++;
        end
    endtask : wait_lvl
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // watchdog well beyond the expected run length
    initial begin
        repeat (90000) @(posedge clock);
        n_fail++;
        close_out();
    end
    initial begin
        {rst_n, reg_write, reg_read, want_jack, want_mic, want_btn} = 6'h0;
        {reg_addr, reg_wdata} = 16'h0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        rd(8'h0d, d); check(d, 8'h00);
        rd(8'h0e, d); check(d, 8'h00);
        v = 8'(xs()) | 8'h10;
        wr(v, 8'hff);
        rd(v, d); check(d, 8'h00);
        $display("reset and unmapped test done");
        // random config b values; never both stereo bits, zero low bits
        for (int i = 0; i < 8; i++) begin
            v = 8'(xs()) & 8'hc8;
            if (v[6]) v[3] = 1'b0;
            wr(8'h0e, v);
            check({coupling_ac, stereo_fully_diff, 2'h0, stereo_pseudo_diff, 3'h0}, v & 8'hc8);
            rd(8'h0e, d); check(d, v);
            check({7'h0, stereo_pseudo_diff}, {7'h0, v[3]});
        end
        $display("config b test done");
        // every legal jack debounce code, plug then unplug
        for (int c = 0; c < 6; c++) begin
            t = tc << (c + 1);
            wr(8'h0d, {3'h4, 3'(c), 2'h0});
            want_jack = 1'b1;
            wait_lvl(1'b1, 12 * t, n);
            check(8'(n >= 7 * t && n <= 10 * t), 8'h01);
            check({6'h0, headset_type}, {6'h0, headset_detect_pkg::type_no_mic});
            want_jack = 1'b0;
            wait_lvl(1'b0, 12 * t, n);
            check(8'(n >= 7 * t && n <= 10 * t), 8'h01);
        end
        $display("jack debounce test done");
        wr(8'h0d, 8'h80);
        {want_jack, want_mic} = 2'h3;
        repeat (100) @(negedge clock);
        rd(8'h0d, d); check(d, 8'he0);
        // every button code: not early (codes 1..3 only), sticky after release, cleared by read
        for (int b = 0; b < 4; b++) begin
            t = (b == 0) ? 1 : tc << (b - 1);
            wr(8'h0d, {6'h20, 2'(b)});
            rd(8'h0e, d);
            want_btn = 1'b1;
            repeat (6 * t) @(negedge clock);
            // no early read in bypass mode: it would clear the fresh flag
            if (b != 0) begin
                rd(8'h0e, d);
                check(d & 8'h20, 8'h00);
            end
            repeat (6 * t) @(negedge clock);
            want_btn = 1'b0;
            repeat (12 * t + 8) @(negedge clock);
            rd(8'h0e, d); check(d & 8'h30, 8'h30);
            rd(8'h0e, d); check(d & 8'h20, 8'h00);
        end
        $display("button test done");
        // disabled: results cleared and presses ignored
        wr(8'h0d, 8'h01);
        repeat (4) @(negedge clock);
        check({5'h0, headset_present, headset_type}, 8'h00);
        want_btn = 1'b1;
        repeat (16 * tc) @(negedge clock);
        rd(8'h0e, d); check(d & 8'h30, 8'h00);
        $display("disable test done");
        close_out();
    end
endmodule : test_headset_button_detect
bind headset_button_detect headset_button_detect_checker chk (.clock, .rst_n, .button_sense,
    .reg_addr, .reg_write, .reg_wdata, .reg_read, .reg_rdata, .headset_present,
    .headset_type, .coupling_ac, .stereo_fully_diff, .stereo_pseudo_diff);
